/* File: rtl/pml_master.sv */
// protection master: stage timers, collective signals, blockings, direction, axi4-lite regs
// Operation
// R1: function inactive or blocked disables all stages
// R2: external block inputs block whole protection
// R3: permanent trip-command block suppresses all commands
// R4: external trip-command block input suppresses commands
// R5: stage alarm as soon as criterion seen
// R6: general alarm is OR of stage alarms
// R7: stage trips when criterion outlasts delay
// R8: general trip is OR of stage trips
// R9: trip command issued unless trip command blocked
// R10: per-phase alarm collective OR
// R11: per-phase trip collective OR
// R12: supervision-only stage reports nothing to master
// R13: supervision-only stage never issues trip command
// R14: ground stage alarm sets ground alarm
// R15: phase-selective stage flags faulty phases
// R16: phase-selective trip drives collective phase trips
// R17: available only without edits and valid measurements
// R18: small phasors report direction not possible
// R19: directional stages trip only in set direction
// R20: forward within ninety degrees of direction angle
// R21: all outputs evaluated and registered each cycle
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pml_master (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [pml_pkg::ADDR_W-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [pml_pkg::ADDR_W-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // external block pins (asynchronous)
   input wire logic ext_block_input_a,
   input wire logic ext_block_input_b,
   input wire logic ext_trip_command_block_input,
   // stage fault criteria and measurement state (same clock)
   input wire pml_pkg::pml_fault_t [pml_pkg::N_STAGES-1:0] stage_fault,
   input wire logic param_changing,
   input wire logic meas_ok,
   input wire logic phasor_too_small,
   input wire logic [pml_pkg::ANG_W-1:0] op_angle,
   input wire logic [pml_pkg::ANG_W-1:0] pol_angle,
   // outputs
   output pml_pkg::pml_collect_t collect,
   output logic [pml_pkg::N_STAGES-1:0] trip_command,
   output logic [pml_pkg::N_STAGES-1:0] stage_alarm,
   output logic [pml_pkg::N_STAGES-1:0] stage_trip,
   output logic prot_active,
   output logic prot_available,
   output pml_pkg::pml_dir_t direction
);
   localparam int N = pml_pkg::N_STAGES;

   // decode a stage index from a byte address; returns N when not a stage register
   function automatic logic [2:0] stage_idx(input logic [pml_pkg::ADDR_W-1:0] a);
      logic [pml_pkg::ADDR_W-1:0] off;
      off = a - pml_pkg::STG_BASE;
      if (a >= pml_pkg::STG_BASE && off[7:2] < 6'(N))
         stage_idx = off[4:2];
      else
         stage_idx = 3'(N);
   endfunction

   // ---------------- pin synchronisers ----------------
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] pin_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         s3_r <= 3'h0;
      end else begin
         s1_r <= {ext_trip_command_block_input, ext_block_input_b, ext_block_input_a};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // a level change is accepted only once two late stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pin_r <= 3'h0;
      else begin
         for (int k = 0; k < 3; k++) begin
            if (s2_r[k] == s3_r[k])
               pin_r[k] <= s3_r[k];
         end
      end
   end

   // ---------------- registers ----------------
   logic [3:0] ctrl_r;
   logic [pml_pkg::ANG_W-1:0] mta_r;
   pml_pkg::pml_stage_cfg_t [N-1:0] cfg_r;
   logic aw_held_r;
   logic w_held_r;
   logic [pml_pkg::ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic do_write;
   logic wr_ctrl;
   logic wr_mta;
   logic wr_known;
   logic [2:0] widx;

   assign do_write = aw_held_r && w_held_r && !s_bvalid;
   // write decode is shared by the response code and the register updates
   assign widx = stage_idx(awaddr_r);
   assign wr_ctrl = awaddr_r == pml_pkg::CTRL_ADDR;
   assign wr_mta = awaddr_r == pml_pkg::MTA_ADDR;
   assign wr_known = wr_ctrl || wr_mta || widx != 3'(N);

   // address and data may arrive in either order; each is held until both are present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
      end else begin
         s_awready <= !aw_held_r && !(s_awvalid && s_awready);
         s_wready <= !w_held_r && !(s_wvalid && s_wready);
         if (s_awvalid && s_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_awaddr;
         end else if (do_write)
            aw_held_r <= 1'b0;
         if (s_wvalid && s_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_wdata;
            wstrb_r <= s_wstrb;
         end else if (do_write)
            w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp <= pml_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         if (wr_known)
            s_bresp <= pml_pkg::RESP_OKAY;
         else
            s_bresp <= pml_pkg::RESP_SLVERR;
      end else if (s_bready)
         s_bvalid <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= pml_pkg::CTRL_RST;
         mta_r <= pml_pkg::MTA_RST;
      end else if (do_write) begin
         if (wr_ctrl && wstrb_r[0])
            ctrl_r <= wdata_r[3:0];
         if (wr_mta && wstrb_r[0])
            mta_r <= wdata_r[pml_pkg::ANG_W-1:0];
      end
   end

   generate
      for (genvar g = 0; g < N; g++) begin : g_cfg
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cfg_r[g].supv_only <= 1'b0;
               cfg_r[g].phase_sel <= 1'b0;
               cfg_r[g].ground <= 1'b0;
               cfg_r[g].directional <= 1'b0;
               cfg_r[g].reverse <= 1'b0;
               cfg_r[g].delay <= pml_pkg::DLY_RST;
            end else if (do_write && widx == 3'(g)) begin
               if (wstrb_r[0]) begin
                  cfg_r[g].supv_only <= wdata_r[pml_pkg::SC_SUPV_BIT];
                  cfg_r[g].phase_sel <= wdata_r[pml_pkg::SC_PSEL_BIT];
                  cfg_r[g].ground <= wdata_r[pml_pkg::SC_GND_BIT];
                  cfg_r[g].directional <= wdata_r[pml_pkg::SC_DIR_BIT];
                  cfg_r[g].reverse <= wdata_r[pml_pkg::SC_REV_BIT];
               end
               if (wstrb_r[2])
                  cfg_r[g].delay[7:0] <= wdata_r[pml_pkg::SC_DLY_LSB +: 8];
               if (wstrb_r[3])
                  cfg_r[g].delay[15:8] <= wdata_r[pml_pkg::SC_DLY_LSB + 8 +: 8];
            end
         end
      end
   endgenerate

   // ---------------- protection enable and blockings ----------------
   logic prot_on;
   logic trip_command_blocked;
   assign prot_on = ctrl_r[pml_pkg::CTRL_FUNC_BIT]                                 // [R1]
      && !(ctrl_r[pml_pkg::CTRL_EXBLK_BIT] && (pin_r[0] || pin_r[1]));             // [R2]
   assign trip_command_blocked = ctrl_r[pml_pkg::CTRL_PTCB_BIT]                          // [R3]
      || (ctrl_r[pml_pkg::CTRL_EXTCB_BIT] && pin_r[2]);                            // [R4]

   // ---------------- direction ----------------
   // angles are binary fractions of a turn; forward means the operating angle lies
   // within a quarter turn either side of the direction angle
   logic [pml_pkg::ANG_W-1:0] rel_ang;
   pml_pkg::pml_dir_t dir_now;
   assign rel_ang = op_angle - pol_angle - mta_r;
   always_comb begin
      if (phasor_too_small)
         dir_now = pml_pkg::PML_DIR_NONE;                                          // [R18]
      else if (rel_ang[7] == rel_ang[6])
         dir_now = pml_pkg::PML_DIR_FWD;                                           // [R20]
      else
         dir_now = pml_pkg::PML_DIR_REV;                                           // [R20]
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         direction <= pml_pkg::PML_DIR_NONE;
      else
         direction <= dir_now;
   end

   // ---------------- stages ----------------
   logic [N-1:0] alarm_nxt;
   logic [N-1:0] trip_nxt;
   logic [2:0] ph_alarm [N];
   logic [2:0] ph_trip [N];
   logic [N-1:0] rep_alarm;
   logic [N-1:0] rep_trip;
   logic [N-1:0] rep_gnd;
   generate
      for (genvar g = 0; g < N; g++) begin : g_stage
         logic [pml_pkg::DLY_W-1:0] cnt_r;
         logic dir_ok;
         logic crit;
         logic [2:0] ph_sel;
         // a directional stage with no decision available holds off
         assign dir_ok = !cfg_r[g].directional
            || (cfg_r[g].reverse ? dir_now == pml_pkg::PML_DIR_REV
                                 : dir_now == pml_pkg::PML_DIR_FWD);                // [R19]
         assign crit = prot_on && dir_ok
            && (|stage_fault[g].phase || stage_fault[g].ground);                    // [R1]
         assign alarm_nxt[g] = crit;                                                // [R5]
         always_ff @(posedge aclk) begin
            if (!aresetn)
               cnt_r <= '0;
            else if (!crit)
               cnt_r <= '0;
            else if (cnt_r != cfg_r[g].delay)
               cnt_r <= cnt_r + 1'b1;
         end
         assign trip_nxt[g] = crit && cnt_r == cfg_r[g].delay;                      // [R7]
         // a stage that cannot tell phases apart adds nothing to the phase collectives
         assign ph_sel = cfg_r[g].phase_sel ? stage_fault[g].phase : 3'h0;
         assign ph_alarm[g] = (crit && !cfg_r[g].supv_only) ? ph_sel : 3'h0;        // [R15]
         assign ph_trip[g] = (trip_nxt[g] && !cfg_r[g].supv_only) ? ph_sel : 3'h0;  // [R16]
         assign rep_alarm[g] = alarm_nxt[g] && !cfg_r[g].supv_only;                 // [R12]
         assign rep_trip[g] = trip_nxt[g] && !cfg_r[g].supv_only;                   // [R12]
         assign rep_gnd[g] = rep_alarm[g] && cfg_r[g].ground;                       // [R14]
      end
   endgenerate

   // ---------------- collective signals ----------------
   pml_pkg::pml_collect_t coll_nxt;
   logic general_trip_now;
   always_comb begin
      coll_nxt.general_alarm = |rep_alarm;                                          // [R6]
      coll_nxt.general_trip = |rep_trip;                                            // [R8]
      coll_nxt.ground_alarm = |rep_gnd;                                             // [R14]
      coll_nxt.phase_alarm = 3'h0;
      coll_nxt.phase_trip = 3'h0;
      for (int k = 0; k < N; k++) begin
         coll_nxt.phase_alarm = coll_nxt.phase_alarm | ph_alarm[k];                 // [R10]
         coll_nxt.phase_trip = coll_nxt.phase_trip | ph_trip[k];                    // [R11]
      end
   end
   assign general_trip_now = coll_nxt.general_trip;

   // a supervision-only stage has no command and so nothing for a blocking to act on
   logic [N-1:0] cmd_nxt;
   always_comb begin
      cmd_nxt = '0;
      for (int k = 0; k < N; k++)
         cmd_nxt[k] = general_trip_now && rep_trip[k]
            && !cfg_r[k].supv_only && !trip_command_blocked;  // [R9] [R13]
   end

   // every output is recomputed each cycle, so a blocking takes effect on the next edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         collect <= '0;
         stage_alarm <= '0;
         stage_trip <= '0;
         trip_command <= '0;
      end else begin
         collect <= coll_nxt;                                                      // [R21]
         stage_alarm <= alarm_nxt;
         stage_trip <= trip_nxt;
         trip_command <= cmd_nxt;  // [R9] [R21]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_active <= 1'b0;
         prot_available <= 1'b0;
      end else begin
         prot_active <= prot_on;
         prot_available <= prot_on && !param_changing && meas_ok;                   // [R17]
      end
   end

   // ---------------- read channel ----------------
   logic [31:0] rd_val;
   logic [31:0] stat_word;
   logic [31:0] cfg_word;
   logic [2:0] ridx;
   logic any_ph_alarm;
   logic any_ph_trip;
   logic rd_ok;
   pml_pkg::pml_stage_cfg_t cfg_sel;
   // the phase collectives are folded to one bit each in the status word
   assign any_ph_alarm = |collect.phase_alarm;
   assign any_ph_trip = |collect.phase_trip;
   assign stat_word = {20'h0, direction, prot_available, prot_active, pin_r,
                       collect.general_alarm, collect.general_trip, collect.ground_alarm,
                       any_ph_alarm, any_ph_trip};
   assign ridx = stage_idx(s_araddr);
   assign cfg_sel = cfg_r[ridx[1:0]];
   assign cfg_word = {cfg_sel.delay, 11'h0, cfg_sel.reverse, cfg_sel.directional,
                      cfg_sel.ground, cfg_sel.phase_sel, cfg_sel.supv_only};
   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      if (s_araddr == pml_pkg::CTRL_ADDR)
         rd_val = {28'h0, ctrl_r};
      else if (s_araddr == pml_pkg::MTA_ADDR)
         rd_val = {24'h0, mta_r};
      else if (s_araddr == pml_pkg::STAT_ADDR)
         rd_val = stat_word;
      else if (s_araddr == pml_pkg::TRIPC_ADDR)
         rd_val = {20'h0, stage_trip, stage_alarm, trip_command};
      else if (ridx != 3'(N))
         rd_val = cfg_word;
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= pml_pkg::RESP_OKAY;
      end else begin
         s_arready <= !s_rvalid && !(s_arvalid && s_arready);
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_val;
            s_rresp <= rd_ok ? pml_pkg::RESP_OKAY : pml_pkg::RESP_SLVERR;
         end else if (s_rready)
            s_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/pml_pkg.sv */
// package: constants, register map and types for the protection master logic
package pml_pkg;
   localparam int N_STAGES = 4;
   localparam int ADDR_W = 8;
   localparam int DLY_W = 16;
   localparam int ANG_W = 8;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] MTA_ADDR = 8'h04;
   localparam logic [7:0] STAT_ADDR = 8'h08;
   localparam logic [7:0] TRIPC_ADDR = 8'h0c;
   localparam logic [7:0] STG_BASE = 8'h10;
   // ctrl fields
   localparam int CTRL_FUNC_BIT = 0;
   localparam int CTRL_EXBLK_BIT = 1;
   localparam int CTRL_PTCB_BIT = 2;
   localparam int CTRL_EXTCB_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h1;
   localparam logic [ANG_W-1:0] MTA_RST = 8'h00;
   // stage cfg fields
   localparam int SC_SUPV_BIT = 0;
   localparam int SC_PSEL_BIT = 1;
   localparam int SC_GND_BIT = 2;
   localparam int SC_DIR_BIT = 3;
   localparam int SC_REV_BIT = 4;
   localparam int SC_DLY_LSB = 16;
   localparam logic [DLY_W-1:0] DLY_RST = 16'h000a;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {PML_DIR_NONE, PML_DIR_FWD, PML_DIR_REV} pml_dir_t;

   typedef struct packed {
      logic supv_only;
      logic phase_sel;
      logic ground;
      logic directional;
      logic reverse;
      logic [DLY_W-1:0] delay;
   } pml_stage_cfg_t;

   typedef struct packed {
      logic [2:0] phase;
      logic ground;
   } pml_fault_t;

   typedef struct packed {
      logic general_alarm;
      logic general_trip;
      logic ground_alarm;
      logic [2:0] phase_alarm;
      logic [2:0] phase_trip;
   } pml_collect_t;
endpackage

/* File: verification/pml_stage_model.sv */
// behavioural protection stages that feed fault criteria to the master
`timescale 1ns/1ps
`default_nettype none
module pml_stage_model (
   // clock
   input wire logic aclk,
   // criteria requested by the test sequence
   input wire pml_pkg::pml_fault_t [pml_pkg::N_STAGES-1:0] fault_cmd,
   input wire logic slow,
   // criteria seen by the master
   output var pml_pkg::pml_fault_t [pml_pkg::N_STAGES-1:0] stage_fault
);
   pml_pkg::pml_fault_t [pml_pkg::N_STAGES-1:0] lag_r;
   // a slow stage reports one cycle later, like a longer measuring window
   always_ff @(posedge aclk) begin
      lag_r <= fault_cmd;
      stage_fault <= slow ? lag_r : fault_cmd;
   end
endmodule
`default_nettype wire

/* File: verification/pml_master_monitor.sv */
// assertion checker on the protection master ports
`timescale 1ns/1ps
`default_nettype none
module pml_master_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // stage side
   input wire pml_pkg::pml_fault_t [pml_pkg::N_STAGES-1:0] stage_fault,
   input wire logic param_changing,
   input wire logic meas_ok,
   input wire logic phasor_too_small,
   // results
   input wire pml_pkg::pml_collect_t collect,
   input wire logic [pml_pkg::N_STAGES-1:0] trip_command,
   input wire logic [pml_pkg::N_STAGES-1:0] stage_alarm,
   input wire logic [pml_pkg::N_STAGES-1:0] stage_trip,
   input wire logic prot_active,
   input wire logic prot_available,
   input wire pml_pkg::pml_dir_t direction
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_off; (|stage_alarm) |-> prot_active; endproperty
   a_off: assert property (p_off) else $error("alarm while protection off");
   property p_crit; (stage_fault[0] == '0) |=> !stage_alarm[0]; endproperty
   a_crit: assert property (p_crit) else $error("alarm without criterion");
   property p_galm; collect.general_alarm |-> (|stage_alarm); endproperty
   a_galm: assert property (p_galm) else $error("general alarm without source");
   property p_tdly; (stage_trip & ~stage_alarm) == '0; endproperty
   a_tdly: assert property (p_tdly) else $error("trip without criterion");
   property p_gtrp; collect.general_trip |-> (|stage_trip); endproperty
   a_gtrp: assert property (p_gtrp) else $error("general trip without source");
   property p_cmd; (|trip_command) |-> collect.general_trip; endproperty
   a_cmd: assert property (p_cmd) else $error("command without general trip");
   property p_palm; (|collect.phase_alarm) |-> collect.general_alarm; endproperty
   a_palm: assert property (p_palm) else $error("phase alarm alone");
   property p_ptrp; (|collect.phase_trip) |-> collect.general_trip; endproperty
   a_ptrp: assert property (p_ptrp) else $error("phase trip alone");
   property p_gnd; collect.ground_alarm |-> collect.general_alarm; endproperty
   a_gnd: assert property (p_gnd) else $error("ground alarm alone");
   property p_avl; prot_available |-> $past(meas_ok) && !$past(param_changing); endproperty
   a_avl: assert property (p_avl) else $error("available while not allowed");
   property p_dir; phasor_too_small |=> direction == pml_pkg::PML_DIR_NONE; endproperty
   a_dir: assert property (p_dir) else $error("direction given on small phasors");
   c_trip: cover property (collect.general_trip);
   c_cmd: cover property (|trip_command);
   c_rev: cover property (direction == pml_pkg::PML_DIR_REV);
endmodule
bind pml_master pml_master_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
   .stage_fault(stage_fault), .param_changing(param_changing), .meas_ok(meas_ok),
   .phasor_too_small(phasor_too_small), .collect(collect), .trip_command(trip_command),
   .stage_alarm(stage_alarm), .stage_trip(stage_trip), .prot_active(prot_active),
   .prot_available(prot_available), .direction(direction));
`default_nettype wire

/* File: verification/test_pml_master.sv */
// self-checking bench for the protection master logic
`timescale 1ns/1ps
`default_nettype none
module test_pml_master;
   logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, prot_active, prot_available;
   logic ext_block_input_a, ext_block_input_b, ext_trip_command_block_input;
   logic param_changing, meas_ok, phasor_too_small, slow;
   logic [7:0] s_awaddr, s_araddr, op_angle, pol_angle;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0] s_wstrb, trip_command, stage_alarm, stage_trip;
   logic [1:0] s_bresp, s_rresp;
   pml_pkg::pml_fault_t [pml_pkg::N_STAGES-1:0] fault_cmd, stage_fault;
   pml_pkg::pml_collect_t collect;
   pml_pkg::pml_dir_t direction;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   localparam logic [1:0] OK = pml_pkg::RESP_OKAY;
   localparam logic [7:0] CT = pml_pkg::CTRL_ADDR;
   localparam logic [7:0] SG = pml_pkg::STG_BASE;
   pml_master uut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .ext_block_input_a(ext_block_input_a),
      .ext_block_input_b(ext_block_input_b),
      .ext_trip_command_block_input(ext_trip_command_block_input),
      .stage_fault(stage_fault), .param_changing(param_changing), .meas_ok(meas_ok),
      .phasor_too_small(phasor_too_small), .op_angle(op_angle), .pol_angle(pol_angle),
      .collect(collect), .trip_command(trip_command), .stage_alarm(stage_alarm),
      .stage_trip(stage_trip), .prot_active(prot_active),
      .prot_available(prot_available), .direction(direction));
   pml_stage_model partner (.aclk(aclk), .fault_cmd(fault_cmd), .slow(slow),
      .stage_fault(stage_fault));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a hung handshake ends here instead of running forever
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch = n_mismatch + 1;
         close_out();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_awready) begin
            aw = 1;
            s_awvalid <= 1'b0;
         end
         if (!w && s_wready) begin
            w = 1;
            s_wvalid <= 1'b0;
         end
      end
      while (!s_bvalid) @(posedge aclk);
      s_bready <= 1'b0;
      chk(32'(s_bresp), 32'(er));
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge aclk); while (!s_arready);
      s_arvalid <= 1'b0;
      while (!s_rvalid) @(posedge aclk);
      s_rready <= 1'b0;
      chk(s_rdata, e);
      chk(32'(s_rresp), 32'(er));
   endtask
   initial begin
      aresetn = 1'b0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, param_changing, slow} = '0;
      {s_awaddr, s_araddr, op_angle, pol_angle, s_wdata} = '0;
      {ext_block_input_a, ext_block_input_b, ext_trip_command_block_input} = '0;
      {meas_ok, phasor_too_small} = 2'b11;
      s_wstrb = 4'hf;
      fault_cmd = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CT, 32'h1, OK);
      rd(pml_pkg::MTA_ADDR, 32'h0, OK);
      rd(SG, 32'h000a0000, OK);
      rd(pml_pkg::STAT_ADDR, 32'h300, OK);
      rd(8'h40, 32'h0, pml_pkg::RESP_SLVERR);
      wr(8'h40, 32'h1, pml_pkg::RESP_SLVERR);
      $display("test reset done");
      wr(SG, 32'h00020002, OK);
      wr(SG + 8'h04, 32'h00020004, OK);
      @(posedge aclk);
      fault_cmd[0] <= 4'b0010;
      fault_cmd[1] <= 4'b0001;
      step(2);
      chk(32'(stage_trip), 32'h0);
      step(6);
      chk(32'(collect), 32'h1c9);
      rd(pml_pkg::TRIPC_ADDR, 32'h333, OK);
      rd(pml_pkg::STAT_ADDR, 32'h31f, OK);
      $display("test collect done");
      wr(CT, 32'h5, OK);
      step(3);
      rd(pml_pkg::TRIPC_ADDR, 32'h330, OK);
      wr(CT, 32'h9, OK);
      @(posedge aclk);
      ext_trip_command_block_input <= 1'b1;
      step(8);
      chk(32'(trip_command), 32'h0);
      @(posedge aclk);
      ext_trip_command_block_input <= 1'b0;
      step(8);
      chk(32'(trip_command), 32'h3);
      for (int i = 0; i < 2; i++) begin
         wr(CT, 32'h3, OK);
         @(posedge aclk);
         {ext_block_input_b, ext_block_input_a} <= 2'(1 << i);
         step(8);
         chk(32'({prot_active, collect}), 32'h0);
         @(posedge aclk);
         {ext_block_input_b, ext_block_input_a} <= 2'b00;
         step(8);
         chk(32'({prot_active, collect}), 32'h3c9);
      end
      wr(CT, 32'h0, OK);
      step(3);
      chk(32'({prot_active, collect}), 32'h0);
      wr(CT, 32'h1, OK);
      $display("test blocking done");
      wr(SG, 32'h00020003, OK);
      @(posedge aclk);
      fault_cmd[1] <= '0;
      slow <= 1'b1;
      step(8);
      chk(32'(collect), 32'h0);
      rd(pml_pkg::TRIPC_ADDR, 32'h110, OK);
      $display("test supervision done");
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk);
         {param_changing, meas_ok} <= (i == 0) ? 2'b11 : 2'(i - 1);
         step(3);
         chk(32'(prot_available), 32'(i == 2));
      end
      $display("test availability done");
      wr(SG, 32'h00020008, OK);
      wr(pml_pkg::MTA_ADDR, 32'h40, OK);
      rd(pml_pkg::MTA_ADDR, 32'h40, OK);
      @(posedge aclk);
      {phasor_too_small, slow} <= 2'b00;
      op_angle <= 8'h40;
      step(8);
      chk(32'(direction), 32'(pml_pkg::PML_DIR_FWD));
      rd(pml_pkg::TRIPC_ADDR, 32'h111, OK);
      @(posedge aclk);
      op_angle <= 8'hc0;
      step(8);
      chk(32'(direction), 32'(pml_pkg::PML_DIR_REV));
      rd(pml_pkg::TRIPC_ADDR, 32'h0, OK);
      wr(SG, 32'h00020018, OK);
      step(8);
      rd(pml_pkg::TRIPC_ADDR, 32'h111, OK);
      @(posedge aclk);
      phasor_too_small <= 1'b1;
      step(3);
      chk(32'(direction), 32'(pml_pkg::PML_DIR_NONE));
      rd(pml_pkg::TRIPC_ADDR, 32'h0, OK);
      $display("test direction done");
      close_out();
   end
endmodule
`default_nettype wire
